// ===== src/sfcd_dev.sv
// Device end: decodes erase, suspend, status, identification and security commands
// Notes on behaviour
// RULE_01 - Opcode is eight bits, lane-dependent clock count; code always sends it on OP_LANES = 1 lane in 8 clocks
// RULE_02 - Address is 24 bits: 24/12/6 clocks
// RULE_03 - Data byte takes 8/4/2 clocks per lanes
// RULE_04 - Dual read mode byte takes 4 clocks
// RULE_05 - Quad reads mode byte takes 2 clocks
// RULE_06 - Continuous read frames start with address
// RULE_07 - Chip erase, suspend, resume: opcode only
// RULE_08 - Block and security erase: opcode plus address
// RULE_09 - Status reads return one byte after opcode
// RULE_10 - Status writes send one byte after opcode
// RULE_11 - ID read: address, optional dummy, two bytes
// RULE_12 - Quad ID: quad address, 4 dummies, quad data
// RULE_13 - Parameter table: address, 8 dummies, stream
// RULE_14 - Unique ID: 32 dummies then stream
// RULE_15 - MSB first; chip select frames operations
// RULE_16 - Unknown opcode ignored until chip select cycles
// RULE_17 - Early chip select release abandons command
// RULE_18 - Writes need write enable; count within frame
// RULE_19 - Drive lanes only in read data phase
`timescale 1ns/1ps
module sfcd_dev (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    sfcd_link_if.dev link,
    input wire logic [7:0] i_rd_byte,
    output logic o_rd_req,
    output logic o_cmd_valid,
    output logic [7:0] o_cmd_op,
    output logic [23:0] o_cmd_addr,
    output logic o_wr_valid,
    output logic [7:0] o_wr_byte,
    output logic o_wel,
    output logic o_cont
);

    ////////////////////////////////////////////////////////////////////////////////
    // Link synchronisers and edge detection
    logic sclk_m;
    logic sclk_s;
    logic sclk_d;
    logic cs_m;
    logic cs_s;
    logic cs_d;
    logic [3:0] io_m;
    logic [3:0] io_s;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sclk_m <= sfcd_pkg::SCLK_RESET;
            sclk_s <= sfcd_pkg::SCLK_RESET;
            sclk_d <= sfcd_pkg::SCLK_RESET;
            cs_m <= sfcd_pkg::CS_N_RESET;
            cs_s <= sfcd_pkg::CS_N_RESET;
            cs_d <= sfcd_pkg::CS_N_RESET;
            io_m <= 4'h0;
            io_s <= 4'h0;
        end else begin
            sclk_m <= link.sclk;
            sclk_s <= sclk_m;
            sclk_d <= sclk_s;
            cs_m <= link.cs_n;
            cs_s <= cs_m;
            cs_d <= cs_s;
            io_m <= link.io;
            io_s <= io_m;
        end
    end

    wire rise = sclk_s & ~sclk_d;
    wire fall = ~sclk_s & sclk_d;
    wire start = ~cs_s & cs_d;
    wire release_cs = cs_s & ~cs_d;

    ////////////////////////////////////////////////////////////////////////////////
    // Phase decode
    sfcd_pkg::sfcd_phase_t ph;
    sfcd_pkg::sfcd_cmd_t dsc;
    logic [7:0] op;
    logic [23:0] addr;
    logic [5:0] cnt;
    logic [31:0] sh;
    logic [7:0] obuf;
    logic [1:0] nb;
    logic drv;
    logic wel;
    logic cont;

    wire in_frame = ph == sfcd_pkg::PH_OPC || ph == sfcd_pkg::PH_ADDR || ph == sfcd_pkg::PH_MODE ||
        ph == sfcd_pkg::PH_DUMMY || ph == sfcd_pkg::PH_DATA;
    wire [2:0] in_ln = (ph == sfcd_pkg::PH_OPC) ? sfcd_pkg::OP_LANES :
        (ph == sfcd_pkg::PH_DATA) ? dsc.da_ln : dsc.ad_ln;
    wire [31:0] sh_nx = sfcd_pkg::sfcd_shift(sh, io_s, in_ln, 1'h1); // [RULE_15]
    wire [5:0] len = sfcd_pkg::sfcd_len(ph, dsc); // [RULE_01] [RULE_02] [RULE_03] [RULE_04] [RULE_05]
    wire last = cnt == len - 6'h01;
    wire sfcd_pkg::sfcd_cmd_t nd = sfcd_pkg::sfcd_decode(sh_nx[7:0]);
    wire refuse = ~nd.ok | (nd.wen & ~wel); // [RULE_16] [RULE_18]
    wire is_opc = ph == sfcd_pkg::PH_OPC;
    wire sfcd_pkg::sfcd_cmd_t cur = is_opc ? nd : dsc;
    wire sfcd_pkg::sfcd_phase_t hdr_nx = sfcd_pkg::sfcd_next(ph, cur); // [RULE_07] [RULE_08] [RULE_09]
    wire wr_full = dsc.max_b != 2'h0 && nb + 2'h1 == dsc.max_b; // [RULE_10]
    wire is_data = ph == sfcd_pkg::PH_DATA;
    wire sfcd_pkg::sfcd_phase_t ph_after = (is_opc && refuse) ? sfcd_pkg::PH_IGNORE :
        !is_data ? hdr_nx :
        (wr_full && !dsc.rd) ? sfcd_pkg::PH_END : sfcd_pkg::PH_DATA;
    wire step = rise && in_frame;
    wire hdr_done = step && last && !is_data && ph_after == sfcd_pkg::PH_DATA;
    wire cmd_now = hdr_done || (release_cs && ph == sfcd_pkg::PH_END && dsc.da_ln == 3'h0); // [RULE_17]
    wire wr_now = step && last && is_data && !dsc.rd;
    wire rd_phase = is_data && dsc.rd && !cs_s;

    ////////////////////////////////////////////////////////////////////////////////
    // Phase sequencer
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ph <= sfcd_pkg::PH_IDLE;
            cnt <= 6'h00;
            sh <= 32'h0;
            op <= 8'h0;
            dsc <= '0;
        end else if (cs_s) begin
            ph <= sfcd_pkg::PH_IDLE; // [RULE_15] [RULE_17]
            cnt <= 6'h00;
        end else if (start) begin
            ph <= cont ? sfcd_pkg::PH_ADDR : sfcd_pkg::PH_OPC; // [RULE_06]
            cnt <= 6'h00;
        end else if (step) begin
            sh <= sh_nx;
            cnt <= last ? 6'h00 : cnt + 6'h01;
            if (last) begin
                ph <= ph_after;
            end
            if (last && is_opc) begin
                op <= sh_nx[7:0];
                dsc <= nd;
            end
        end else if (rise && ph == sfcd_pkg::PH_END) begin
            ph <= sfcd_pkg::PH_IGNORE; // [RULE_07]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Command, write data and mode state
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            addr <= 24'h0;
            o_cmd_valid <= 1'h0;
            o_cmd_op <= 8'h0;
            o_cmd_addr <= 24'h0;
        end else begin
            o_cmd_valid <= cmd_now;
            if (step && last && is_opc) begin
                addr <= 24'h0;
            end else if (step && last && ph == sfcd_pkg::PH_ADDR) begin
                addr <= sh_nx[23:0];
            end
            if (cmd_now) begin
                o_cmd_op <= is_opc ? sh_nx[7:0] : op;
                o_cmd_addr <= (ph == sfcd_pkg::PH_ADDR) ? sh_nx[23:0] : is_opc ? 24'h0 : addr;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wel <= 1'h0;
            cont <= 1'h0;
            nb <= 2'h0;
            o_wr_valid <= 1'h0;
            o_wr_byte <= 8'h0;
        end else begin
            o_wr_valid <= wr_now;
            if (start) begin
                nb <= 2'h0; // [RULE_18]
            end else if (wr_now) begin
                nb <= nb + 2'h1;
                o_wr_byte <= sh_nx[7:0]; // [RULE_10]
            end
            if (cmd_now && !is_opc && op == sfcd_pkg::OP_WR_ENABLE) begin
                wel <= 1'h1;
            end else if (cmd_now && (cur.wen || (!is_opc && op == sfcd_pkg::OP_WR_DISABLE))) begin
                wel <= 1'h0; // [RULE_18]
            end
            if (step && last && ph == sfcd_pkg::PH_MODE) begin
                cont <= sh_nx[5:4] == sfcd_pkg::CONT_KEY; // [RULE_06]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data output, changed on the falling serial edge
    assign o_rd_req = fall && rd_phase && cnt == 6'h00; // [RULE_09] [RULE_11] [RULE_13] [RULE_14]

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            obuf <= 8'h0;
            drv <= 1'h0;
        end else if (!rd_phase) begin
            drv <= 1'h0; // [RULE_19]
        end else if (o_rd_req) begin
            obuf <= i_rd_byte;
            drv <= 1'h1;
        end else if (fall) begin
            obuf <= obuf << dsc.da_ln; // [RULE_03] [RULE_12]
        end
    end

    assign link.d_io = sfcd_pkg::sfcd_put(obuf, dsc.da_ln, 1'h1); // [RULE_15]
    assign link.d_oe = drv ? sfcd_pkg::sfcd_put(8'hff, dsc.da_ln, 1'h1) : 4'h0; // [RULE_19]
    assign o_wel = wel;
    assign o_cont = cont;

endmodule

// ===== src/sfcd_pkg.sv
// Shared constants, command table and helper functions for the serial flash command link
package sfcd_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Opcodes
    localparam logic [7:0] OP_ERASE_4K = 8'h20;
    localparam logic [7:0] OP_ERASE_32K = 8'h52;
    localparam logic [7:0] OP_ERASE_64K = 8'hd8;
    localparam logic [7:0] OP_ERASE_CHIP_A = 8'hc7;
    localparam logic [7:0] OP_ERASE_CHIP_B = 8'h60;
    localparam logic [7:0] OP_SUSPEND = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7a;
    localparam logic [7:0] OP_RD_STAT1 = 8'h05;
    localparam logic [7:0] OP_RD_STAT2 = 8'h35;
    localparam logic [7:0] OP_RD_STAT3 = 8'h15;
    localparam logic [7:0] OP_WR_STAT1 = 8'h01;
    localparam logic [7:0] OP_WR_STAT2 = 8'h31;
    localparam logic [7:0] OP_WR_STAT3 = 8'h11;
    localparam logic [7:0] OP_ID_SINGLE = 8'h90;
    localparam logic [7:0] OP_ID_DUAL = 8'h92;
    localparam logic [7:0] OP_ID_QUAD = 8'h94;
    localparam logic [7:0] OP_ID_JEDEC = 8'h9f;
    localparam logic [7:0] OP_PARAM_TABLE = 8'h5a;
    localparam logic [7:0] OP_SEC_ERASE = 8'h44;
    localparam logic [7:0] OP_SEC_PROG = 8'h42;
    localparam logic [7:0] OP_SEC_READ = 8'h48;
    localparam logic [7:0] OP_UNIQUE_ID = 8'h4b;
    localparam logic [7:0] OP_DUAL_IO_RD = 8'hbb;
    localparam logic [7:0] OP_QUAD_IO_RD = 8'heb;
    localparam logic [7:0] OP_QUAD_WORD_RD = 8'he7;
    localparam logic [7:0] OP_WR_ENABLE = 8'h06;
    localparam logic [7:0] OP_WR_DISABLE = 8'h04;

    ////////////////////////////////////////////////////////////////////////////////
    // Field sizes and reset values
    localparam logic [5:0] OPC_BITS = 6'h08;
    localparam logic [5:0] ADDR_BITS = 6'h18;
    localparam logic [5:0] BYTE_BITS = 6'h08;
    localparam logic [2:0] OP_LANES = 3'h1;
    localparam logic [1:0] CONT_KEY = 2'h2;
    localparam logic CS_N_RESET = 1'h1;
    localparam logic SCLK_RESET = 1'h0;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_OPC,
        PH_ADDR,
        PH_MODE,
        PH_DUMMY,
        PH_DATA,
        PH_END,
        PH_IGNORE
    } sfcd_phase_t;

    // Lane counts are 0, 1, 2 or 4; max_b of zero means no byte limit
    typedef struct packed {
        logic ok;
        logic [2:0] ad_ln;
        logic [2:0] mode_clk;
        logic [5:0] dmy_clk;
        logic [2:0] da_ln;
        logic rd;
        logic wen;
        logic [1:0] max_b;
    } sfcd_cmd_t;

    function automatic sfcd_cmd_t sfcd_mk(input logic [2:0] ad, input logic [2:0] md, input logic [5:0] dm,
                                          input logic [2:0] da, input logic rd, input logic wen,
                                          input logic [1:0] mb);
        return '{ok: 1'h1, ad_ln: ad, mode_clk: md, dmy_clk: dm, da_ln: da, rd: rd, wen: wen, max_b: mb};
    endfunction

    function automatic sfcd_cmd_t sfcd_decode(input logic [7:0] op);
        case (op)
            OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K, OP_SEC_ERASE:
                return sfcd_mk(3'h1, 3'h0, 6'h00, 3'h0, 1'h0, 1'h1, 2'h0);
            OP_ERASE_CHIP_A, OP_ERASE_CHIP_B:
                return sfcd_mk(3'h0, 3'h0, 6'h00, 3'h0, 1'h0, 1'h1, 2'h0);
            OP_SUSPEND, OP_RESUME, OP_WR_ENABLE, OP_WR_DISABLE:
                return sfcd_mk(3'h0, 3'h0, 6'h00, 3'h0, 1'h0, 1'h0, 2'h0);
            OP_RD_STAT1, OP_RD_STAT2, OP_RD_STAT3:
                return sfcd_mk(3'h0, 3'h0, 6'h00, 3'h1, 1'h1, 1'h0, 2'h1);
            OP_WR_STAT1, OP_WR_STAT2, OP_WR_STAT3:
                return sfcd_mk(3'h0, 3'h0, 6'h00, 3'h1, 1'h0, 1'h1, 2'h1);
            OP_ID_SINGLE: return sfcd_mk(3'h1, 3'h0, 6'h00, 3'h1, 1'h1, 1'h0, 2'h2);
            OP_ID_DUAL: return sfcd_mk(3'h2, 3'h0, 6'h04, 3'h2, 1'h1, 1'h0, 2'h2);
            OP_ID_QUAD: return sfcd_mk(3'h4, 3'h0, 6'h04, 3'h4, 1'h1, 1'h0, 2'h2);
            OP_ID_JEDEC: return sfcd_mk(3'h0, 3'h0, 6'h00, 3'h1, 1'h1, 1'h0, 2'h3);
            OP_PARAM_TABLE, OP_SEC_READ:
                return sfcd_mk(3'h1, 3'h0, 6'h08, 3'h1, 1'h1, 1'h0, 2'h0);
            OP_SEC_PROG: return sfcd_mk(3'h1, 3'h0, 6'h00, 3'h1, 1'h0, 1'h1, 2'h0);
            OP_UNIQUE_ID: return sfcd_mk(3'h0, 3'h0, 6'h20, 3'h1, 1'h1, 1'h0, 2'h0);
            OP_DUAL_IO_RD: return sfcd_mk(3'h2, 3'h4, 6'h00, 3'h2, 1'h1, 1'h0, 2'h0);
            OP_QUAD_IO_RD: return sfcd_mk(3'h4, 3'h2, 6'h04, 3'h4, 1'h1, 1'h0, 2'h0);
            OP_QUAD_WORD_RD: return sfcd_mk(3'h4, 3'h2, 6'h02, 3'h4, 1'h1, 1'h0, 2'h0);
            default: return '0;
        endcase
    endfunction

    function automatic logic [5:0] sfcd_clks(input logic [5:0] bits, input logic [2:0] ln);
        if (ln == 3'h4) begin
            return bits >> 2;
        end
        if (ln == 3'h2) begin
            return bits >> 1;
        end
        return bits;
    endfunction

    // Serial clocks spent in a phase
    function automatic logic [5:0] sfcd_len(input sfcd_phase_t ph, input sfcd_cmd_t d);
        case (ph)
            PH_OPC: return sfcd_clks(OPC_BITS, OP_LANES);
            PH_ADDR: return sfcd_clks(ADDR_BITS, d.ad_ln);
            PH_MODE: return {3'h0, d.mode_clk};
            PH_DUMMY: return d.dmy_clk;
            default: return sfcd_clks(BYTE_BITS, d.da_ln);
        endcase
    endfunction

    // Phase that follows a finished header phase
    function automatic sfcd_phase_t sfcd_next(input sfcd_phase_t ph, input sfcd_cmd_t d);
        sfcd_phase_t n;
        n = PH_END;
        if (d.da_ln != 3'h0) begin
            n = PH_DATA;
        end
        if (ph != PH_DUMMY && d.dmy_clk != 6'h00) begin
            n = PH_DUMMY;
        end
        if ((ph == PH_OPC || ph == PH_ADDR) && d.mode_clk != 3'h0) begin
            n = PH_MODE;
        end
        if (ph == PH_OPC && d.ad_ln != 3'h0) begin
            n = PH_ADDR;
        end
        return n;
    endfunction

    // Lane values for the top bits of a byte; single lane is io1 from the device, io0 from the host
    function automatic logic [3:0] sfcd_put(input logic [7:0] b, input logic [2:0] ln, input logic dev);
        if (ln == 3'h4) begin
            return b[7:4];
        end
        if (ln == 3'h2) begin
            return {2'h0, b[7:6]};
        end
        return dev ? {2'h0, b[7], 1'h0} : {3'h0, b[7]};
    endfunction

    // Shift lane values in, MSB first
    function automatic logic [31:0] sfcd_shift(input logic [31:0] sh, input logic [3:0] io, input logic [2:0] ln,
                                               input logic dev);
        if (ln == 3'h4) begin
            return {sh[27:0], io};
        end
        if (ln == 3'h2) begin
            return {sh[29:0], io[1:0]};
        end
        return {sh[30:0], dev ? io[0] : io[1]};
    endfunction

endpackage

// ===== src/sfcd_link_if.sv
// Serial flash link between the host controller and the command decoder
`timescale 1ns/1ps
interface sfcd_link_if;
    logic sclk;
    logic cs_n;
    logic [3:0] h_io;
    logic [3:0] h_oe;
    logic [3:0] d_io;
    logic [3:0] d_oe;
    logic [3:0] io;

    // Wire level of the four lanes; undriven lanes float high
    assign io = (d_io & d_oe) | (h_io & h_oe) | ~(d_oe | h_oe);

    modport dev (input sclk, input cs_n, input io, output d_io, output d_oe);
    modport host (output sclk, output cs_n, output h_io, output h_oe, input io);
endinterface

// ===== src/sfcd_host.sv
// Host end: issues one framed flash command with its address, mode and data phases
`timescale 1ns/1ps
module sfcd_host #(
    parameter int HALF = 4
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    sfcd_link_if.host link,
    input wire logic i_start,
    input wire logic [7:0] i_op,
    input wire logic i_cont,
    input wire logic [23:0] i_addr,
    input wire logic [7:0] i_mode,
    input wire logic [7:0] i_nbytes,
    input wire logic [7:0] i_wr_byte,
    output logic o_wr_req,
    output logic o_rd_valid,
    output logic [7:0] o_rd_byte,
    output logic o_busy
);
    localparam int DW = (HALF > 1) ? $clog2(HALF) : 1;

    // The device needs about three clocks to see a serial edge and answer
    if (HALF < 4) begin : g_bad_half
        $error("HALF must be at least 4");
    end

    sfcd_pkg::sfcd_phase_t ph;
    sfcd_pkg::sfcd_cmd_t dsc;
    logic [DW-1:0] div;
    logic [5:0] cnt;
    logic [31:0] sh;
    logic [31:0] am;
    logic [7:0] rx;
    logic [7:0] nb;
    logic [7:0] n;
    logic last_r;
    logic sclk;
    logic cs_n;

    wire tick = div == DW'(HALF - 1);
    wire is_data = ph == sfcd_pkg::PH_DATA;
    wire [2:0] ln = (ph == sfcd_pkg::PH_OPC) ? sfcd_pkg::OP_LANES : is_data ? dsc.da_ln : dsc.ad_ln;
    wire last = cnt == sfcd_pkg::sfcd_len(ph, dsc) - 6'h01; // [RULE_01] [RULE_02] [RULE_03]
    wire sfcd_pkg::sfcd_phase_t hdr = sfcd_pkg::sfcd_next(ph, dsc);
    wire sfcd_pkg::sfcd_phase_t nph = is_data ? ((nb == n) ? sfcd_pkg::PH_END : sfcd_pkg::PH_DATA) :
        (hdr == sfcd_pkg::PH_DATA && n == 8'h0) ? sfcd_pkg::PH_END : hdr;
    wire [7:0] rx_nx = 8'(sfcd_pkg::sfcd_shift({24'h0, rx}, link.io, ln, 1'h0));
    wire fall_now = ph != sfcd_pkg::PH_IDLE && tick && sclk;
    wire drive = ph == sfcd_pkg::PH_OPC || ph == sfcd_pkg::PH_ADDR || ph == sfcd_pkg::PH_MODE ||
        (is_data && !dsc.rd);

    assign o_wr_req = fall_now && last_r && nph == sfcd_pkg::PH_DATA && !dsc.rd; // [RULE_10]
    assign o_busy = ph != sfcd_pkg::PH_IDLE;
    assign link.sclk = sclk;
    assign link.cs_n = cs_n;
    assign link.h_io = sfcd_pkg::sfcd_put(sh[31:24], ln, 1'h0); // [RULE_15]
    assign link.h_oe = drive ? sfcd_pkg::sfcd_put(8'hff, ln, 1'h0) : 4'h0;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div <= '0;
        end else if (ph == sfcd_pkg::PH_IDLE || tick) begin
            div <= '0;
        end else begin
            div <= div + DW'(1);
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rd_valid <= 1'h0;
            o_rd_byte <= 8'h0;
            rx <= 8'h0;
        end else begin
            o_rd_valid <= 1'h0;
            if (ph != sfcd_pkg::PH_IDLE && tick && !sclk && is_data && dsc.rd) begin
                rx <= rx_nx;
                o_rd_valid <= last;
                if (last) begin
                    o_rd_byte <= rx_nx;
                end
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ph <= sfcd_pkg::PH_IDLE;
            dsc <= '0;
            cnt <= 6'h00;
            sh <= 32'h0;
            am <= 32'h0;
            nb <= 8'h0;
            n <= 8'h0;
            last_r <= 1'h0;
            sclk <= sfcd_pkg::SCLK_RESET;
            cs_n <= sfcd_pkg::CS_N_RESET;
        end else if (ph == sfcd_pkg::PH_IDLE) begin
            if (i_start) begin
                cs_n <= 1'h0; // [RULE_15]
                ph <= i_cont ? sfcd_pkg::PH_ADDR : sfcd_pkg::PH_OPC; // [RULE_06]
                dsc <= sfcd_pkg::sfcd_decode(i_op);
                sh <= i_cont ? {i_addr, i_mode} : {i_op, 24'h0};
                am <= {i_addr, i_mode};
                n <= i_nbytes;
                nb <= 8'h0;
                cnt <= 6'h00;
                last_r <= 1'h0;
            end
        end else if (tick && !sclk) begin
            if (ph == sfcd_pkg::PH_END) begin
                cs_n <= 1'h1;
                ph <= sfcd_pkg::PH_IDLE;
            end else begin
                sclk <= 1'h1;
                cnt <= last ? 6'h00 : cnt + 6'h01;
                last_r <= last;
                if (last && is_data) begin
                    nb <= nb + 8'h1;
                end
            end
        end else if (fall_now) begin
            sclk <= 1'h0;
            if (last_r) begin
                ph <= nph; // [RULE_04] [RULE_05]
            end
            if (last_r && nph == sfcd_pkg::PH_ADDR) begin
                sh <= am;
            end else if (o_wr_req) begin
                sh <= {i_wr_byte, 24'h0};
            end else begin
                sh <= sh << ln;
            end
        end
    end

endmodule

// ===== verif/sfcd_chk.sv
// Link checker for the serial flash command link
`timescale 1ns/1ps
module sfcd_chk (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic [3:0] h_io,
    input wire logic [3:0] h_oe,
    input wire logic [3:0] d_io,
    input wire logic [3:0] d_oe
);
    logic sclk_q;
    logic [5:0] rises;
    // Serial clock rises since chip select fell
    wire logic sclk_up = sclk && !sclk_q;
    wire logic [5:0] next_rises = cs_n ? 6'h00 : rises + {5'h00, sclk_up && rises != 6'h3f};
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sclk_q <= 1'h0;
            rises <= 6'h00;
        end else begin
            sclk_q <= sclk;
            rises <= next_rises;
        end
    end
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    a_release_on_cs: assert property ($rose(cs_n) |-> ##[0:5] d_oe == 4'h0)
        else $error("device lanes held after deselect");
    a_no_contention: assert property ((d_oe & h_oe) == 4'h0)
        else $error("both ends drive a lane");
    a_dev_lane_set: assert property (d_oe inside {4'h0, 4'h2, 4'h3, 4'hf})
        else $error("device drives an illegal lane set");
    a_sclk_idle_low: assert property (cs_n |-> !sclk)
        else $error("serial clock high while deselected");
    a_cs_steady_high: assert property (sclk |-> $stable(cs_n))
        else $error("chip select moved while clock high");
    a_host_lane_hold: assert property (sclk && $past(sclk) |-> $stable(h_io & h_oe))
        else $error("host lanes changed while clock high");
    a_dev_lane_hold: assert property (sclk && $past(sclk) |-> $stable(d_io & d_oe))
        else $error("device lanes changed while clock high");
    a_quiet_in_opc: assert property (!cs_n && rises < 6'h08 |-> d_oe == 4'h0)
        else $error("device drove during header");
    a_host_idle: assert property (cs_n && $past(cs_n) && $past(cs_n, 2) |-> h_oe == 4'h0)
        else $error("host drives lanes while idle");
    c_quad_data: cover property (d_oe == 4'hf);
    c_dual_data: cover property (d_oe == 4'h3);
    c_opc_only: cover property ($rose(cs_n) && rises == 6'h08);
endmodule

// ===== verif/tb_serial_flash_cmd_decoder.sv
// Self-checking bench: host and device ends joined over the serial link
`timescale 1ns/1ps
module tb_serial_flash_cmd_decoder;
    logic clk = 1'h0, rst_n = 1'h0, start = 1'h0, cont = 1'h0;
    logic [7:0] op = 8'h00, mode = 8'h00, nb = 8'h00, wb = 8'h00, rb = 8'h00;
    logic [23:0] addr = 24'h000000;
    wire logic rd_req, cmd_v, wr_v, wel, armed, wr_req, rd_v, busy;
    wire logic [7:0] cmd_op, wr_byte, rd_byte;
    wire logic [23:0] cmd_addr;
    int err_total = 0, n_compared = 0;
    logic [31:0] q_cmd[$];
    logic [7:0] q_rd[$], q_wr[$];
    logic [15:0] rd_tab[10] = '{16'h0501, 16'h3501, 16'h1501, 16'h9002, 16'h9202, 16'h9402, 16'h5a03, 16'h4801,
                                16'h4b02, 16'h9f03};
    logic [15:0] wr_tab[11] = '{16'h2000, 16'h5200, 16'hd800, 16'h4400, 16'hc700, 16'h6000,
                                16'h0101, 16'h3101, 16'h1101, 16'h4202, 16'h0400};
    logic [7:0] cr_tab[3] = '{8'hbb, 8'heb, 8'he7};
    sfcd_link_if sfcd_link_if_i ();
    sfcd_host #(.HALF(4)) sfcd_host_i (.i_ref_clk(clk), .i_rst_n(rst_n), .link(sfcd_link_if_i), .i_start(start),
        .i_op(op), .i_cont(cont), .i_addr(addr), .i_mode(mode), .i_nbytes(nb), .i_wr_byte(wb), .o_wr_req(wr_req),
        .o_rd_valid(rd_v), .o_rd_byte(rd_byte), .o_busy(busy));
    sfcd_dev sfcd_dev_i (.i_ref_clk(clk), .i_rst_n(rst_n), .link(sfcd_link_if_i), .i_rd_byte(rb), .o_rd_req(rd_req),
        .o_cmd_valid(cmd_v), .o_cmd_op(cmd_op), .o_cmd_addr(cmd_addr), .o_wr_valid(wr_v), .o_wr_byte(wr_byte),
        .o_wel(wel), .o_cont(armed));
    sfcd_chk sfcd_chk_i (.i_ref_clk(clk), .i_rst_n(rst_n), .sclk(sfcd_link_if_i.sclk), .cs_n(sfcd_link_if_i.cs_n),
        .h_io(sfcd_link_if_i.h_io), .h_oe(sfcd_link_if_i.h_oe), .d_io(sfcd_link_if_i.d_io), .d_oe(sfcd_link_if_i.d_oe));
    ////////////////////////////////////////////////////////////
    task automatic report(input string m);
        err_total++;
        $display("[ERR] %0t %s", $time, m);
    endtask
    task automatic chk_cmd(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) report($sformatf("command %h, expected %h", got, exp));
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) report($sformatf("byte %h, expected %h", got, exp));
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) report($sformatf("flag %b, expected %b", got, exp));
    endtask
    task automatic tally_and_finish;
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // One framed command; notes the command, read and write bytes it should yield
    task automatic frame(input logic [7:0] o, input logic c, input logic [7:0] m, input logic [7:0] n, input logic ok);
        int k;
        logic [23:0] a;
        logic [7:0] r, w;
        a = 24'($urandom);
        r = 8'($urandom);
        w = 8'($urandom);
        if (ok) q_cmd.push_back({o, (o inside {8'h20, 8'h52, 8'hd8, 8'h44, 8'h90, 8'h92, 8'h94, 8'h5a, 8'h48, 8'h42,
            8'hbb, 8'heb, 8'he7}) ? a : 24'h000000});
        for (k = 0; k < n; k++) begin
            if (o inside {8'h01, 8'h31, 8'h11, 8'h42}) q_wr.push_back(w);
            else q_rd.push_back(r);
        end
        op <= o;
        cont <= c;
        addr <= a;
        mode <= m;
        nb <= n;
        wb <= w;
        rb <= r;
        start <= 1'h1;
        @(posedge clk);
        start <= 1'h0;
        for (k = 0; k < 6000 && (k < 3 || busy !== 1'h0); k++) @(posedge clk);
        if (k == 6000) begin
            report("frame never ended");
            tally_and_finish();
        end
        repeat (8) @(posedge clk);
        chk_byte(8'(q_cmd.size() + q_rd.size() + q_wr.size()), 8'h00);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        if (cmd_v === 1'h1) begin
            if (q_cmd.size() == 0) report("unexpected command");
            else chk_cmd({cmd_op, cmd_addr}, q_cmd.pop_front());
        end
        if (rd_v === 1'h1) begin
            if (q_rd.size() == 0) report("unexpected read byte");
            else chk_byte(rd_byte, q_rd.pop_front());
        end
        if (wr_v === 1'h1) begin
            if (q_wr.size() == 0) report("unexpected write byte");
            else chk_byte(wr_byte, q_wr.pop_front());
        end
        if (rd_req === 1'h1) chk_flag(busy, 1'h1);
        if (wr_req === 1'h1) chk_flag(q_wr.size() != 0, 1'h1);
    end
    initial begin
        void'($urandom(32'hbc84f24e));
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        foreach (rd_tab[i]) frame(rd_tab[i][15:8], 1'h0, 8'h00, rd_tab[i][7:0], 1'h1);
        frame(8'h20, 1'h0, 8'h00, 8'h00, 1'h0);
        frame(8'h99, 1'h0, 8'h00, 8'h00, 1'h0);
        frame(8'h75, 1'h0, 8'h00, 8'h00, 1'h1);
        frame(8'h7a, 1'h0, 8'h00, 8'h00, 1'h1);
        foreach (wr_tab[i]) begin
            frame(8'h06, 1'h0, 8'h00, 8'h00, 1'h1);
            chk_flag(wel, 1'h1);
            frame(wr_tab[i][15:8], 1'h0, 8'h00, wr_tab[i][7:0], 1'h1);
            chk_flag(wel, 1'h0);
        end
        foreach (cr_tab[i]) begin
            frame(cr_tab[i], 1'h0, 8'h20, 8'h02, 1'h1);
            chk_flag(armed, 1'h1);
            frame(cr_tab[i], 1'h1, 8'h20, 8'h01, 1'h1);
            frame(cr_tab[i], 1'h1, 8'hc0, 8'h01, 1'h1);
            chk_flag(armed, 1'h0);
        end
        frame(8'h05, 1'h0, 8'h00, 8'h01, 1'h1);
        tally_and_finish();
    end
endmodule
